/* File: logic/cirl_map.vh */
// register map and timing constants of the interrupt request logic
// assumes inclusion by bare name from the design file
`ifndef CIRL_MAP_VH
`define CIRL_MAP_VH

// word addresses (byte address = 4 x index)
`define CIRL_ADR_CTRL 4'h0
`define CIRL_ADR_PFLAG 4'h1
`define CIRL_ADR_PEN 4'h2
`define CIRL_ADR_EVT 4'h3
`define CIRL_ADR_EMASK 4'h4
`define CIRL_ADR_CORE 4'h5

// control register bit positions; CIRL_B_CMP is bit 0 of the comparator flag and enable registers
`define CIRL_B_GIE 7
`define CIRL_B_TIE 5
`define CIRL_B_EIE 4
`define CIRL_B_PCIE 3
`define CIRL_B_TIF 2
`define CIRL_B_EIF 1
`define CIRL_B_PCIF 0
`define CIRL_B_CMP 0

// reset values
`define CIRL_CTRL_RST 8'h00
`define CIRL_BYTE_RST 8'h00

// vector loaded into the program counter on acceptance
`define CIRL_VECTOR 13'h0004
// latency count before take; vec_take comes five cycles after the event edge, four after the request
`define CIRL_LAT_MIN 2'h3
`define CIRL_LAT_ONE 2'h1

`endif

/* File: logic/cirl_irq_logic.v */
// interrupt request logic: four sources, flags, enables, global enable, vectoring
// assumes one instruction cycle per sys_clk edge and a core sequencer that honours vec_take
//
// Contract
// - exactly four sources: pin, timer, port, comparator
// - control register holds flags, enables, global enable
// - global enable at bit 7 gates the core request, not the irq_o summary
// - each source masked by its own enable
// - reset clears the global enable
// - return instruction sets the global enable
// - pin, port, timer flags in control register
// - comparator flag and enable in own registers
// - acceptance clears enable, pushes, loads vector 0004h
// - pin and port events reach vector in 3-4 cycles; here vec_take follows the event edge by five cycles
// - latency independent of instruction length
// - flags set regardless of any enable
// - cycle after global clear is a no-op, no take
// - suppressed requests stay pending until re-enabled
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "cirl_map.vh"

module cirl_irq_logic #(
  parameter PORT_W = 4,
  parameter PC_W = 13
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  output wire wb_err_o,
  // source events, synchronous to sys_clk
  input wire external_edge_irq_pin,
  input wire timer_zero_ovf,
  input wire [PORT_W-1:0] upper_port_change_pins,
  input wire comparator_evt,
  // core sequencer
  input wire return_from_irq_instr,
  input wire gie_clear_instr,
  input wire [PC_W-1:0] core_pc,
  output wire core_irq_req,
  output reg vec_take,
  output reg [PC_W-1:0] vec_addr,
  output reg push_stack,
  output reg [PC_W-1:0] push_addr,
  output reg core_nop,
  // summary interrupt
  output wire irq_o
);

  reg [7:0] irq_control_reg_q;
  reg [7:0] peripheral_flag_reg_q;
  reg [7:0] peripheral_enable_reg_q;
  reg [7:0] evt_status_q;
  reg [7:0] evt_mask_q;
  reg ack_q;
  reg pin_q;
  reg [PORT_W-1:0] port_q;
  reg [1:0] lat_q;
  reg nop_q;

  wire wr;
  wire rd_ok;
  wire hit;
  wire pin_evt;
  wire port_evt;
  wire [3:0] pend;
  wire want;
  wire take;
  wire [7:0] ctrl_set;
  wire [7:0] wb_byte;

  // one-cycle answer; ack drops the cycle after it was given
  assign hit = (wb_adr_i <= `CIRL_ADR_CORE);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && hit && wb_sel_i[0] && !ack_q;
  assign rd_ok = wb_cyc_i && wb_stb_i && !ack_q;
  assign wb_ack_o = ack_q && hit;
  assign wb_err_o = ack_q && !hit;
  assign wb_byte = wb_dat_i[7:0];

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= rd_ok;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_adr_i == `CIRL_ADR_CTRL) begin
      wb_dat_o <= {24'h00_0000, irq_control_reg_q};
    end else if (wb_adr_i == `CIRL_ADR_PFLAG) begin
      wb_dat_o <= {24'h00_0000, peripheral_flag_reg_q};
    end else if (wb_adr_i == `CIRL_ADR_PEN) begin
      wb_dat_o <= {24'h00_0000, peripheral_enable_reg_q};
    end else if (wb_adr_i == `CIRL_ADR_EVT) begin
      wb_dat_o <= {24'h00_0000, evt_status_q};
    end else if (wb_adr_i == `CIRL_ADR_EMASK) begin
      wb_dat_o <= {24'h00_0000, evt_mask_q};
    end else if (wb_adr_i == `CIRL_ADR_CORE) begin
      wb_dat_o <= {30'h0000_0000, core_nop, core_irq_req};
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  // edge detectors; the pin interrupt takes the rising edge
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= 1'b0;
      port_q <= {PORT_W{1'b0}};
    end else begin
      pin_q <= external_edge_irq_pin;
      port_q <= upper_port_change_pins;
    end
  end

  assign pin_evt = external_edge_irq_pin && !pin_q;
  assign port_evt = |(upper_port_change_pins ^ port_q);

  // hardware sets win over software clears in the same cycle
  assign ctrl_set = {5'b00000, timer_zero_ovf, pin_evt, port_evt};

  assign pend[0] = irq_control_reg_q[`CIRL_B_PCIF] && irq_control_reg_q[`CIRL_B_PCIE];
  assign pend[1] = irq_control_reg_q[`CIRL_B_EIF] && irq_control_reg_q[`CIRL_B_EIE];
  assign pend[2] = irq_control_reg_q[`CIRL_B_TIF] && irq_control_reg_q[`CIRL_B_TIE];
  assign pend[3] = peripheral_flag_reg_q[`CIRL_B_CMP] && peripheral_enable_reg_q[`CIRL_B_CMP];
  assign want = irq_control_reg_q[`CIRL_B_GIE] && (|pend);
  assign core_irq_req = want;

  // pending requests stay in the flags while the global enable is low, so
  // nothing is lost when the enable returns; the cycle after a global clear
  // is blanked so an in-flight request cannot slip past it
  assign take = want && (lat_q == `CIRL_LAT_MIN) && !nop_q && !gie_clear_instr && !vec_take;

  // latency counts instruction cycles only, never instruction length
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lat_q <= 2'h0;
    end else if (!want || vec_take) begin
      lat_q <= 2'h0;
    end else if (lat_q != `CIRL_LAT_MIN) begin
      lat_q <= lat_q + `CIRL_LAT_ONE;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      nop_q <= 1'b0;
      core_nop <= 1'b0;
    end else begin
      nop_q <= gie_clear_instr;
      core_nop <= gie_clear_instr;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vec_take <= 1'b0;
      vec_addr <= {PC_W{1'b0}};
      push_stack <= 1'b0;
      push_addr <= {PC_W{1'b0}};
    end else begin
      vec_take <= take;
      push_stack <= take;
      if (take) begin
        vec_addr <= `CIRL_VECTOR;
        push_addr <= core_pc;
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_control_reg_q <= `CIRL_CTRL_RST;
    end else begin
      if (wr && wb_adr_i == `CIRL_ADR_CTRL) begin
        irq_control_reg_q <= wb_byte | ctrl_set;
      end else begin
        irq_control_reg_q <= irq_control_reg_q | ctrl_set;
      end
      if (take || gie_clear_instr) begin
        irq_control_reg_q[`CIRL_B_GIE] <= 1'b0;
      end else if (return_from_irq_instr) begin
        irq_control_reg_q[`CIRL_B_GIE] <= 1'b1;
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      peripheral_flag_reg_q <= `CIRL_BYTE_RST;
      peripheral_enable_reg_q <= `CIRL_BYTE_RST;
    end else begin
      if (wr && wb_adr_i == `CIRL_ADR_PFLAG) begin
        peripheral_flag_reg_q <= (wb_byte & 8'h01) | {7'h00, comparator_evt};
      end else begin
        peripheral_flag_reg_q <= peripheral_flag_reg_q | {7'h00, comparator_evt};
      end
      if (wr && wb_adr_i == `CIRL_ADR_PEN) begin
        peripheral_enable_reg_q <= wb_byte & 8'h01;
      end
    end
  end

  // summary status: bit0 port, bit1 pin, bit2 timer, bit3 comparator, bit4 vector taken
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_status_q <= `CIRL_BYTE_RST;
      evt_mask_q <= `CIRL_BYTE_RST;
    end else begin
      if (wr && wb_adr_i == `CIRL_ADR_EVT) begin
        evt_status_q <= (evt_status_q & ~wb_byte) | {3'b000, take, comparator_evt, ctrl_set[2:0]};
      end else begin
        evt_status_q <= evt_status_q | {3'b000, take, comparator_evt, ctrl_set[2:0]};
      end
      if (wr && wb_adr_i == `CIRL_ADR_EMASK) begin
        evt_mask_q <= wb_byte & 8'h1F;
      end
    end
  end

  assign irq_o = |(evt_status_q & evt_mask_q);

endmodule // cirl_irq_logic

/* File: verification/cirl_irq_monitor.sv */
// checker for the interrupt request logic, watching only its top ports
// assumes one sys_clk domain with async active-low reset_n
`timescale 1ns/100ps
module cirl_irq_monitor #(
  parameter PC_W = 13
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // core side and summary interrupt
  input wire gie_clear_instr,
  input wire [PC_W-1:0] core_pc,
  input wire core_irq_req,
  input wire vec_take,
  input wire [PC_W-1:0] vec_addr,
  input wire push_stack,
  input wire [PC_W-1:0] push_addr,
  input wire core_nop,
  input wire irq_o
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_vec_value: assert property (vec_take |-> vec_addr == 13'h0004)
    else $error("vector address wrong on take");
  chk_push_pair: assert property (vec_take == push_stack)
    else $error("push and take not paired");
  chk_push_pc: assert property (vec_take |-> push_addr == $past(core_pc))
    else $error("pushed address is not the pc at take");
  chk_take_drops: assert property (vec_take |-> !core_irq_req)
    else $error("request still up after take");
  chk_nop_follow: assert property (gie_clear_instr |=> core_nop)
    else $error("no nop after global clear");
  chk_blank_take: assert property (gie_clear_instr |=> !vec_take [*2])
    else $error("take in blanked cycles");
  chk_clear_gates: assert property (gie_clear_instr |=> !core_irq_req)
    else $error("request survives global clear");
  chk_take_latency: assert property ($rose(core_irq_req) |-> ##[3:4] vec_take)
    else $error("take latency out of range");
  cov_take: cover property (vec_take);
  cov_nop: cover property (core_nop);
  cov_irq: cover property ($rose(irq_o));
endmodule // cirl_irq_monitor

bind cirl_irq_logic cirl_irq_monitor #(.PC_W(PC_W)) mon (.sys_clk(sys_clk), .reset_n(reset_n),
  .gie_clear_instr(gie_clear_instr), .core_pc(core_pc), .core_irq_req(core_irq_req), .vec_take(vec_take),
  .vec_addr(vec_addr), .push_stack(push_stack), .push_addr(push_addr), .core_nop(core_nop), .irq_o(irq_o));

/* File: verification/cirl_core_model.sv */
// core sequencer stand-in: runs a pc and jumps to the vector on take
// assumes take and push arrive as one-cycle pulses on sys_clk
`timescale 1ns/100ps
module cirl_core_model (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // from the interrupt logic
  input wire vec_take,
  input wire push_stack,
  input wire [12:0] vec_addr,
  input wire [12:0] push_addr,
  // pc to the interrupt logic, return stack top to the bench
  output logic [12:0] core_pc,
  output logic [12:0] ret_top
);
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_pc <= 13'h0100;
      ret_top <= 13'h0000;
    end else if (vec_take) begin
      core_pc <= vec_addr;
      if (push_stack) ret_top <= push_addr;
    end else core_pc <= core_pc + 13'h0001;
  end
endmodule // cirl_core_model

/* File: verification/test_cpu_interrupt_request_logic.sv */
// bench for the interrupt request logic over wishbone and source pulses
// assumes the core model stands on the sequencer side
`timescale 1ns/100ps
module test_cpu_interrupt_request_logic;
  logic sys_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, pin = 0, tmr = 0, cmp = 0, ret = 0, gclr = 0;
  logic [3:0] adr = 0, port = 0;
  logic [31:0] dat = 0, rdat, rq;
  logic ack, err, req, take, push, nop, irq_o, re;
  logic [12:0] pc, vaddr, paddr, rtop;
  logic [7:0] fl [4] = '{8'h02, 8'h04, 8'h01, 8'h00};
  int failures = 0, num_checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  cirl_irq_logic uut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .external_edge_irq_pin(pin), .timer_zero_ovf(tmr), .upper_port_change_pins(port), .comparator_evt(cmp),
    .return_from_irq_instr(ret), .gie_clear_instr(gclr), .core_pc(pc), .core_irq_req(req), .vec_take(take),
    .vec_addr(vaddr), .push_stack(push), .push_addr(paddr), .core_nop(nop), .irq_o(irq_o));
  cirl_core_model core (.sys_clk(sys_clk), .reset_n(reset_n), .vec_take(take), .push_stack(push),
    .vec_addr(vaddr), .push_addr(paddr), .core_pc(pc), .ret_top(rtop));
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge sys_clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    do begin @(posedge sys_clk); n++; end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    // a bus answer that never comes is a mismatch, not a silent pass
    if (ack !== 1'b1 && err !== 1'b1) failures++;
    rq = rdat;
    re = err;
    cyc <= 0; stb <= 0;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin failures++; $display("[ERR] %s expected %h seen %h", s, e, g); end
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    case (i) 0: pin <= 1; 1: tmr <= 1; 2: port <= ~port; 3: cmp <= 1; 4: ret <= 1; default: gclr <= 1; endcase
    @(posedge sys_clk);
    {pin, tmr, cmp, ret, gclr} <= 5'h00;
  endtask
  task automatic wait_take();
    int n = 0;
    while (take !== 1'b1 && n < 12) begin @(posedge sys_clk); n++; end
    chk("take", 1, take);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1;
    wb(0, 0, 0); chk("ctrl", 0, rq);
    for (int i = 0; i < 4; i++) pulse(i);
    repeat (2) @(posedge sys_clk);
    wb(0, 0, 0); chk("ctrl", 8'h07, rq);
    wb(0, 1, 0); chk("pflag", 1, rq);
    wb(1, 2, 8'h01);
    wb(1, 0, 8'hBF); wait_take();
    wb(0, 0, 0); chk("ctrl", 8'h3F, rq);
    for (int i = 0; i < 4; i++) begin
      wb(1, 1, 0); wb(1, 0, 8'h38); pulse(4);
      wb(0, 0, 0); chk("ctrl", 8'hB8, rq);
      pulse(i); wait_take();
      chk("vec", 4, vaddr);
      wb(0, 0, 0); chk("ctrl", 8'h38 | fl[i], rq);
      wb(0, 1, 0); chk("pflag", i == 3, rq);
    end
    wb(1, 1, 0); wb(1, 0, 8'hA8); pulse(0); repeat (8) @(posedge sys_clk);
    wb(0, 0, 0); chk("ctrl", 8'hAA, rq);
    wb(1, 0, 8'h3A); wb(0, 5, 0); chk("core", 0, rq);
    wb(1, 0, 8'hB8); pulse(5);
    wb(0, 0, 0); chk("ctrl", 8'h38, rq);
    wb(1, 3, 8'h1F); wb(1, 4, 8'h01); pulse(2); repeat (2) @(posedge sys_clk);
    chk("irq", 1, irq_o);
    wb(1, 3, 8'h01); chk("irq", 0, irq_o);
    wb(1, 4, 8'h00); pulse(2); repeat (2) @(posedge sys_clk);
    chk("irq", 0, irq_o);
    wb(0, 3, 0); chk("evt", 8'h01, rq);
    wb(0, 6, 0); chk("unmapped", 0, rq);
    chk("err", 1, re);
    summarize();
  end
  initial begin
    #20000;
    failures++;
    summarize();
  end
endmodule // test_cpu_interrupt_request_logic
